// >>> core/vcw_cfg.svh
/*
  Constants of the output-code window clamp: register offsets, field
  positions, the limits reset value and status bit positions.
  Assumes it is included by bare name from every design file that needs it.
*/
`ifndef VCW_CFG_SVH
`define VCW_CFG_SVH

// register offsets on the plain register port
`define VCW_ADDR_HIGH_SEL 8'h10
`define VCW_ADDR_LOW_SEL 8'h11
`define VCW_ADDR_LIMITS 8'h1e
`define VCW_ADDR_STATUS 8'h1f
`define VCW_ADDR_EFFECTIVE 8'h20

// limit register fields, code field top bit and limits reset value
`define VCW_UPPER_MSB 7
`define VCW_UPPER_LSB 4
`define VCW_LOWER_MSB 3
`define VCW_LOWER_LSB 0
`define VCW_CODE_MSB 6
`define VCW_LIMITS_RESET 8'hf0

// low bits appended to each limit to form the bound codes
`define VCW_UPPER_FILL 3'h7
`define VCW_LOWER_FILL 3'h0

// status register bits
`define VCW_STAT_SEL 0
`define VCW_STAT_HIGH 1
`define VCW_STAT_LOW 2
`define VCW_STAT_INV 3

`define VCW_SYNC_STAGES 2

`endif

// >>> core/vcw_clamp.sv
/*
  Combinational window clamp of the selected output-voltage code.
  Assumes settings and select are already in the clock domain of the caller.
*/
`timescale 1ns/1ps
`default_nettype none
`include "vcw_cfg.svh"

module vcw_clamp (
  input wire logic i_select,
  input wire vcw_pkg::vcw_settings_type i_settings,
  output vcw_pkg::vcw_result_type o_result
);

  vcw_pkg::vcw_code_type chosen;
  vcw_pkg::vcw_code_type upper_bound;
  vcw_pkg::vcw_code_type lower_bound;

  always_comb begin
    chosen = i_select ? i_settings.high_code : i_settings.low_code; // R6
    upper_bound = {i_settings.limits.upper, `VCW_UPPER_FILL};
    lower_bound = {i_settings.limits.lower, `VCW_LOWER_FILL};
    o_result.clamp_high = 1'b0;
    o_result.clamp_low = 1'b0;
    o_result.inverted = lower_bound > upper_bound;
    // upper test first: a code above the upper and below the lower bound takes the upper bound
    if (chosen > upper_bound) begin
      o_result.code = upper_bound; // R2 R3
      o_result.clamp_high = 1'b1;
    end else if (chosen < lower_bound) begin
      o_result.code = lower_bound; // R4 R5
      o_result.clamp_low = 1'b1;
    end else begin
      o_result.code = chosen; // R6
    end
  end

endmodule

`default_nettype wire

// >>> core/vcw_pkg.sv
/*
  Types shared by the output-code window clamp.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package vcw_pkg;

  typedef logic [6:0] vcw_code_type;
  typedef logic [7:0] vcw_byte_type;

  // upper limit in the high nibble, lower limit in the low nibble
  typedef struct packed {
    logic [3:0] upper;
    logic [3:0] lower;
  } vcw_limits_type;

  typedef struct packed {
    vcw_code_type high_code;
    vcw_code_type low_code;
    vcw_limits_type limits;
  } vcw_settings_type;

  typedef struct packed {
    vcw_code_type code;
    logic clamp_high;
    logic clamp_low;
    logic inverted;
  } vcw_result_type;

endpackage

// >>> core/vcw_sync.sv
/*
  Two-stage synchroniser for levels that arrive from outside the clock domain.
  Assumes the input is a level held for at least two clock cycles.
*/
`timescale 1ns/1ps
`default_nettype none
`include "vcw_cfg.svh"

module vcw_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  // refused at elaboration, before any logic is built
  if (WIDTH < 1) begin : g_bad_width
    $error("vcw_sync: WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] stage [`VCW_SYNC_STAGES];
  logic [WIDTH-1:0] next_stage [`VCW_SYNC_STAGES];

  // first stage feeds only the second
  always_comb begin
    next_stage[0] = i_async;
    for (int i = 1; i < `VCW_SYNC_STAGES; i++) begin
      next_stage[i] = stage[i-1];
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < `VCW_SYNC_STAGES; i++) begin
        stage[i] <= '0;
      end
    end else begin
      stage <= next_stage;
    end
  end

  assign o_sync = stage[`VCW_SYNC_STAGES-1];

endmodule

`default_nettype wire

// >>> core/vcw_top.sv
/*
  Output-voltage code window clamp: two stored codes, a select pin, and a
  software window that bounds the code handed to the regulator.
  Assumes a register master on the same clock with one-cycle strobes, and a
  select pin that is asynchronous to i_clk_sys.
*/
// Chosen here: the address-and-strobe port and the placing of the registers.
// How it works
// R1: limits confine effective code, scaling cannot escape
// R2: pin low, code above window: upper bound
// R3: pin high, code above window: upper bound
// R4: pin low, code below window: lower bound
// R5: pin high, code below window: lower bound
// R6: inside window, selected code passes unchanged
// R7: any input change re-evaluates clamp; registered output follows a write in two edges, a pin change in three
`timescale 1ns/1ps
`default_nettype none
`include "vcw_cfg.svh"

module vcw_top #(
  parameter int ADDR_W = 8,
  parameter vcw_pkg::vcw_code_type RESET_HIGH_CODE = 7'h40,
  parameter vcw_pkg::vcw_code_type RESET_LOW_CODE = 7'h20
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_output_setting_select_pin,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire vcw_pkg::vcw_byte_type i_wr_data,
  input wire logic i_wr,
  input wire logic i_rd,
  output vcw_pkg::vcw_byte_type o_rd_data,
  output vcw_pkg::vcw_code_type o_vout_code,
  output logic o_clamp_high,
  output logic o_clamp_low,
  output logic o_window_inverted
);

  // refused at elaboration: narrower buses cannot reach the effective-code register
  if (ADDR_W < 6 || ADDR_W > 16) begin : g_bad_addr_w
    $error("vcw_top: ADDR_W must lie between 6 and 16");
  end

  // address decode
  logic hit_high;
  logic hit_low;
  logic hit_limits;
  logic hit_status;
  logic hit_effective;

  always_comb begin
    hit_high = i_addr == ADDR_W'(`VCW_ADDR_HIGH_SEL);
    hit_low = i_addr == ADDR_W'(`VCW_ADDR_LOW_SEL);
    hit_limits = i_addr == ADDR_W'(`VCW_ADDR_LIMITS);
    hit_status = i_addr == ADDR_W'(`VCW_ADDR_STATUS);
    hit_effective = i_addr == ADDR_W'(`VCW_ADDR_EFFECTIVE);
  end

  // select pin comes from a board pin, so it is synchronised first
  logic select_sync;

  vcw_sync #(
    .WIDTH(1)
  ) u_select_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_async(i_output_setting_select_pin),
    .o_sync(select_sync)
  );

  // stored settings
  vcw_pkg::vcw_settings_type settings;
  vcw_pkg::vcw_settings_type next_settings;

  always_comb begin
    next_settings = settings;
    if (i_wr) begin
      if (hit_high) begin
        next_settings.high_code = i_wr_data[`VCW_CODE_MSB:0];
      end
      if (hit_low) begin
        next_settings.low_code = i_wr_data[`VCW_CODE_MSB:0];
      end
      if (hit_limits) begin
        next_settings.limits.upper = i_wr_data[`VCW_UPPER_MSB:`VCW_UPPER_LSB];
        next_settings.limits.lower = i_wr_data[`VCW_LOWER_MSB:`VCW_LOWER_LSB];
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      settings.high_code <= RESET_HIGH_CODE;
      settings.low_code <= RESET_LOW_CODE;
      settings.limits <= vcw_pkg::vcw_limits_type'(`VCW_LIMITS_RESET);
    end else begin
      settings <= next_settings;
    end
  end

  // clamp is purely combinational, so every change of settings or of the synchronised select is seen the next edge
  vcw_pkg::vcw_result_type result;

  vcw_clamp u_clamp (
    .i_select(select_sync),
    .i_settings(settings),
    .o_result(result)
  );

  // regulator-facing outputs
  vcw_pkg::vcw_code_type next_vout_code;
  logic next_clamp_high;
  logic next_clamp_low;
  logic next_window_inverted;

  always_comb begin
    next_vout_code = result.code; // R1 R7
    next_clamp_high = result.clamp_high;
    next_clamp_low = result.clamp_low;
    next_window_inverted = result.inverted;
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_vout_code <= RESET_LOW_CODE;
      o_clamp_high <= 1'b0;
      o_clamp_low <= 1'b0;
      o_window_inverted <= 1'b0;
    end else begin
      o_vout_code <= next_vout_code;
      o_clamp_high <= next_clamp_high;
      o_clamp_low <= next_clamp_low;
      o_window_inverted <= next_window_inverted;
    end
  end

  // read port: data stands one cycle after the strobe and reads zero otherwise
  vcw_pkg::vcw_byte_type status_word;
  vcw_pkg::vcw_byte_type next_rd_data;

  always_comb begin
    status_word = '0;
    status_word[`VCW_STAT_SEL] = select_sync;
    status_word[`VCW_STAT_HIGH] = o_clamp_high;
    status_word[`VCW_STAT_LOW] = o_clamp_low;
    status_word[`VCW_STAT_INV] = o_window_inverted;
    next_rd_data = '0;
    if (i_rd) begin
      if (hit_high) begin
        next_rd_data = {1'b0, settings.high_code};
      end else if (hit_low) begin
        next_rd_data = {1'b0, settings.low_code};
      end else if (hit_limits) begin
        next_rd_data = vcw_pkg::vcw_byte_type'(settings.limits);
      end else if (hit_status) begin
        next_rd_data = status_word;
      end else if (hit_effective) begin
        next_rd_data = {1'b0, o_vout_code};
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_rd_data <= '0;
    end else begin
      o_rd_data <= next_rd_data;
    end
  end

  // assertion helpers, computed apart from the clamp module
  vcw_pkg::vcw_code_type chk_upper;
  vcw_pkg::vcw_code_type chk_lower;
  logic low_above;
  logic low_below;
  logic high_above;
  logic high_below;
  logic window_crossed;
  logic hit_any;
  vcw_pkg::vcw_code_type wr_code;
  vcw_pkg::vcw_byte_type limits_word;
  vcw_pkg::vcw_byte_type status_expect;

  always_comb begin
    chk_upper = {settings.limits.upper, `VCW_UPPER_FILL};
    chk_lower = {settings.limits.lower, `VCW_LOWER_FILL};
    low_above = settings.low_code > chk_upper;
    low_below = settings.low_code < chk_lower;
    high_above = settings.high_code > chk_upper;
    high_below = settings.high_code < chk_lower;
    window_crossed = chk_lower > chk_upper;
    hit_any = hit_high || hit_low || hit_limits || hit_status || hit_effective;
    wr_code = i_wr_data[`VCW_CODE_MSB:0];
    limits_word = {settings.limits.upper, settings.limits.lower};
    // built apart from the read mux so a swapped status bit shows up
    status_expect = {4'h0, o_window_inverted, o_clamp_low, o_clamp_high, select_sync};
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  sequence s_low_write;
    i_wr && hit_low && !select_sync;
  endsequence

  sequence s_low_settled;
    !select_sync && !low_above && !low_below && $stable(settings.limits);
  endsequence

  sequence s_select_rise;
    $rose(select_sync) && !high_above && !high_below;
  endsequence

  sequence s_high_write;
    i_wr && hit_high && select_sync;
  endsequence

  sequence s_high_settled;
    select_sync && !high_above && !high_below && $stable(settings.limits);
  endsequence

  // window holds whenever limits are sane and steady
  chk_window_bound: assert property ( // R1
    ($stable(settings) && !o_window_inverted && chk_lower <= chk_upper)
      |=> (o_vout_code <= $past(chk_upper) && o_vout_code >= $past(chk_lower))
  ) else $error("effective code left the software window");

  chk_low_over_upper: assert property ( // R2
    (!select_sync && low_above) |=> (o_vout_code == $past(chk_upper) && o_clamp_high)
  ) else $error("low-select code above window not clamped to upper bound");

  chk_high_over_upper: assert property ( // R3
    (select_sync && high_above) |=> (o_vout_code == $past(chk_upper) && o_clamp_high)
  ) else $error("high-select code above window not clamped to upper bound");

  chk_low_under_lower: assert property ( // R4
    (!select_sync && !low_above && low_below)
      |=> (o_vout_code == $past(chk_lower) && o_clamp_low && !o_clamp_high)
  ) else $error("low-select code below window not raised to lower bound");

  chk_high_under_lower: assert property ( // R5
    (select_sync && !high_above && high_below)
      |=> (o_vout_code == $past(chk_lower) && o_clamp_low && !o_clamp_high)
  ) else $error("high-select code below window not raised to lower bound");

  chk_pass_through: assert property ( // R6
    (!select_sync && !low_above && !low_below)
      |=> (o_vout_code == $past(settings.low_code) && !o_clamp_high && !o_clamp_low)
  ) else $error("in-window low-select code was altered");

  chk_write_reaches_out: assert property ( // R7
    s_low_write ##1 s_low_settled |=> o_vout_code == $past(wr_code, 2)
  ) else $error("written low-select code did not reach output in two cycles");

  chk_select_switch: assert property ( // R7
    s_select_rise |=> (o_vout_code == $past(settings.high_code))
  ) else $error("select pin change not followed by high-select code");

  chk_limits_readback: assert property (
    (i_rd && hit_limits) |=> o_rd_data == $past(limits_word)
  ) else $error("limits register read back wrong");

  chk_read_idle_zero: assert property (
    !i_rd |=> o_rd_data == '0
  ) else $error("read data present without a read strobe");

  chk_high_pass_through: assert property ( // R6
    (select_sync && !high_above && !high_below)
      |=> (o_vout_code == $past(settings.high_code) && !o_clamp_high && !o_clamp_low)
  ) else $error("in-window high-select code was altered");

  chk_high_write_out: assert property ( // R7
    s_high_write ##1 s_high_settled |=> o_vout_code == $past(wr_code, 2)
  ) else $error("written high-select code did not reach output in two cycles");

  chk_flags_exclusive: assert property ( // R1
    !(o_clamp_high && o_clamp_low)
  ) else $error("code clamped to both bounds at once");

  // crossed limits are legal to write, so the flag must track them
  chk_inverted_flag: assert property (
    1'b1 |=> o_window_inverted == $past(window_crossed)
  ) else $error("window inverted flag does not follow the limits");

  chk_limits_write_lands: assert property (
    (i_wr && hit_limits) |=> limits_word == $past(i_wr_data)
  ) else $error("limits write did not land");

  chk_high_readback: assert property (
    (i_rd && hit_high) |=> o_rd_data == {1'b0, $past(settings.high_code)}
  ) else $error("high-select code read back wrong");

  chk_low_readback: assert property (
    (i_rd && hit_low) |=> o_rd_data == {1'b0, $past(settings.low_code)}
  ) else $error("low-select code read back wrong");

  chk_status_readback: assert property (
    (i_rd && hit_status) |=> o_rd_data == $past(status_expect)
  ) else $error("status register read back wrong");

  chk_effective_readback: assert property (
    (i_rd && hit_effective) |=> o_rd_data == {1'b0, $past(o_vout_code)}
  ) else $error("effective code read back wrong");

  chk_unmapped_read_zero: assert property (
    (i_rd && !hit_any) |=> o_rd_data == '0
  ) else $error("unmapped address read returned data");

  // read-only and unmapped addresses must leave the stored settings alone
  chk_stray_write_ignored: assert property (
    (i_wr && !hit_high && !hit_low && !hit_limits) |=> $stable(settings)
  ) else $error("write to a read-only or unmapped address changed settings");

endmodule

`default_nettype wire

// >>> verification/tb.sv
/*
  Self-checking testbench of the output-code window clamp.
  Assumes the host model drives the register port and the bench drives the select pin.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin errors++; \
  $display("mismatch %s expected %h seen %h", nm, ex, got); end end

module tb;
  logic i_clk_sys, i_rst, pin, wr, rd, clamp_high, clamp_low, inverted;
  logic [7:0] addr;
  vcw_pkg::vcw_byte_type wr_data, rd_data, d;
  vcw_pkg::vcw_code_type vout;
  int errors = 0;
  int n_compared = 0;

  vcw_top i_vcw_top (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_output_setting_select_pin(pin),
    .i_addr(addr), .i_wr_data(wr_data), .i_wr(wr), .i_rd(rd), .o_rd_data(rd_data),
    .o_vout_code(vout), .o_clamp_high(clamp_high), .o_clamp_low(clamp_low),
    .o_window_inverted(inverted));
  vcw_host i_vcw_host (.i_clk_sys(i_clk_sys), .i_rd_data(rd_data), .o_addr(addr),
    .o_wr_data(wr_data), .o_wr(wr), .o_rd(rd));

  initial begin
    i_clk_sys = 1'b0;
    forever #4 i_clk_sys = ~i_clk_sys;
  end

  function automatic vcw_pkg::vcw_code_type clamp_of(vcw_pkg::vcw_code_type c, logic [3:0] up, logic [3:0] lo);
    if (c > {up, 3'b111}) return {up, 3'b111};
    if (c < {lo, 3'b000}) return {lo, 3'b000};
    return c;
  endfunction

  // the unselected register gets a different code with bit 7 set
  task automatic check_case(input logic sel, input logic [3:0] up, input logic [3:0] lo,
                            input vcw_pkg::vcw_code_type c);
    logic hi_ex, lo_ex;
    hi_ex = c > {up, 3'b111};
    lo_ex = !hi_ex && (c < {lo, 3'b000});
    i_vcw_host.wr_reg(8'h1e, {up, lo});
    i_vcw_host.wr_reg(sel ? 8'h10 : 8'h11, {1'b0, c});
    i_vcw_host.wr_reg(sel ? 8'h11 : 8'h10, {1'b1, ~c});
    @(posedge i_clk_sys);
    pin <= sel;
    repeat (4) @(posedge i_clk_sys);
    #1;
    `CHK("vout", clamp_of(c, up, lo), vout)
    `CHK("clamp_high", hi_ex, clamp_high)
    `CHK("clamp_low", lo_ex, clamp_low)
    `CHK("inverted", lo > up, inverted)
    i_vcw_host.rd_reg(8'h20, d);
    `CHK("effective", {1'b0, clamp_of(c, up, lo)}, d)
  endtask

  task automatic test_reset;
    `CHK("vout_rst", 7'h20, vout)
    i_vcw_host.rd_reg(8'h10, d);
    `CHK("high_rst", 8'h40, d)
    i_vcw_host.rd_reg(8'h11, d);
    `CHK("low_rst", 8'h20, d)
    i_vcw_host.wr_reg(8'h05, 8'h5a);
    i_vcw_host.rd_reg(8'h05, d);
    `CHK("unmapped", 8'h00, d)
    i_vcw_host.rd_reg(8'h1e, d);
    `CHK("limits_rst", 8'hf0, d)
    $display("test reset done");
  endtask

  task automatic test_select(input logic sel);
    check_case(sel, 4'h9, 4'h3, 7'h50);
    check_case(sel, 4'h9, 4'h3, 7'h4f);
    check_case(sel, 4'h9, 4'h3, 7'h18);
    if (sel) begin
      check_case(sel, 4'h9, 4'h3, 7'h7e);
      check_case(sel, 4'h0, 4'h0, 7'h08);
      check_case(sel, 4'h9, 4'h3, 7'h17);
      check_case(sel, 4'hf, 4'hf, 7'h00);
    end else begin
      check_case(sel, 4'h9, 4'h3, 7'h7f);
      check_case(sel, 4'h0, 4'h0, 7'h08);
      check_case(sel, 4'h9, 4'h3, 7'h00);
      check_case(sel, 4'hf, 4'hf, 7'h77);
    end
    $display("test select %0d done", sel);
  endtask

  task automatic test_reeval;
    check_case(1'b0, 4'h5, 4'h2, 7'h00);
    @(posedge i_clk_sys);
    pin <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    #1;
    `CHK("pin_swap", 7'h2f, vout)
    i_vcw_host.wr_reg(8'h1e, 8'h72);
    repeat (2) @(posedge i_clk_sys);
    #1;
    `CHK("limit_swap", 7'h3f, vout)
    @(posedge i_clk_sys);
    pin <= 1'b0;
    i_vcw_host.wr_reg(8'h10, 8'h20);
    i_vcw_host.wr_reg(8'h20, 8'h7f);
    @(posedge i_clk_sys);
    pin <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    #1;
    `CHK("pin_rise", 7'h20, vout)
    i_vcw_host.rd_reg(8'h20, d);
    `CHK("effective_ro", 8'h20, d)
    i_vcw_host.rd_reg(8'h1f, d);
    `CHK("status_pass", 8'h01, d)
    check_case(1'b1, 4'h3, 4'ha, 7'h40);
    i_vcw_host.rd_reg(8'h1f, d);
    `CHK("status_crossed", 8'h0b, d)
    $display("test reeval done");
  endtask

  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    #100000;
    errors++;
    end_of_test();
  end

  initial begin
    i_rst = 1'b1;
    pin = 1'b0;
    repeat (12) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    #1;
    test_reset();
    test_select(1'b0);
    test_select(1'b1);
    test_reeval();
    end_of_test();
  end
endmodule

`default_nettype wire

// >>> verification/vcw_host.sv
/*
  Register host model for the output-code window clamp: plain write and read cycles.
  Assumes the slave answers a read in the cycle after the strobe and never stalls.
*/
`timescale 1ns/1ps
`default_nettype none

module vcw_host (
  input wire logic i_clk_sys,
  input wire vcw_pkg::vcw_byte_type i_rd_data,
  output logic [7:0] o_addr,
  output vcw_pkg::vcw_byte_type o_wr_data,
  output logic o_wr,
  output logic o_rd
);
  initial begin
    o_addr = 8'h00;
    o_wr_data = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end

  // released lines show the inverse so a stale value never looks valid
  task automatic wr_reg(input logic [7:0] a, input vcw_pkg::vcw_byte_type v);
    @(posedge i_clk_sys);
    o_wr <= 1'b1;
    o_addr <= a;
    o_wr_data <= v;
    @(posedge i_clk_sys);
    o_wr <= 1'b0;
    o_addr <= ~a;
    o_wr_data <= ~v;
  endtask

  task automatic rd_reg(input logic [7:0] a, output vcw_pkg::vcw_byte_type v);
    @(posedge i_clk_sys);
    o_rd <= 1'b1;
    o_addr <= a;
    @(posedge i_clk_sys);
    o_rd <= 1'b0;
    o_addr <= ~a;
    #1;
    v = i_rd_data;
  endtask
endmodule

`default_nettype wire
